// ### hdl/dpsa_pkg.sv
// Constants shared by the token-space port controller and its testbench.
// Assumes one 125 MHz clock and a single-port attachment to the dual-port part.
package dpsa_pkg;

    localparam int CLK_PERIOD_NS = 8;
    localparam int CNT_W = 8;
    localparam int TOKEN_COUNT = 8;
    localparam int TOKEN_AW = 3;
    localparam int DATA_W = 16;

    // Address and enable must settle before the write pulse starts
    localparam int T_BUSY_SETTLE_NS = 20;
    localparam int T_WRITE_PULSE_NS = 15;
    localparam int T_READ_ACCESS_NS = 20;
    localparam int T_RECOVERY_NS = 10;
    // Latency of the three-stage synchroniser plus the agreement stage
    localparam int SYNC_LAT_CYC = 4;
    // Re-reads of a busy token after the first readback before the request is withdrawn
    localparam logic [3:0] POLL_LIMIT = 4'h8;

    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int SETTLE_CYC_I = cyc_up(T_BUSY_SETTLE_NS);
    localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYC_I - 1);
    localparam logic [CNT_W-1:0] WPULSE_LOAD = CNT_W'(cyc_up(T_WRITE_PULSE_NS) - 1);
    localparam logic [CNT_W-1:0] READ_LOAD = CNT_W'(cyc_up(T_READ_ACCESS_NS) + SYNC_LAT_CYC - 1);
    localparam logic [CNT_W-1:0] RECOV_LOAD = CNT_W'(cyc_up(T_RECOVERY_NS) - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    localparam logic [1:0] OP_POLL = 2'h0;
    localparam logic [1:0] OP_ACQUIRE = 2'h1;
    localparam logic [1:0] OP_RELEASE = 2'h2;
    localparam logic [1:0] OP_INIT = 2'h3;

    localparam logic [TOKEN_AW-1:0] TOKEN_FIRST = 3'h0;
    localparam logic [TOKEN_AW-1:0] TOKEN_LAST = 3'h7;
    localparam logic [TOKEN_AW-1:0] TOKEN_STEP = 3'h1;
    localparam logic [3:0] POLL_STEP = 4'h1;

    typedef enum logic [2:0] {
        DPSA_IDLE,
        DPSA_SETUP,
        DPSA_WPULSE,
        DPSA_WRECOV,
        DPSA_READ,
        DPSA_GAP,
        DPSA_DONE
    } dpsa_state_t;

endpackage

// ### hdl/dpsa_in_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes inputs idle high; output moves only once stages two and three agree.
`timescale 1ns/1ps
module dpsa_in_sync #(
    parameter int W = 2
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } dpsa_sync_t;

    dpsa_sync_t r;
    dpsa_sync_t next_r;

    always_comb begin
        next_r = r;
        next_r.s1 = d_i;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        // First stage feeds only the second; the filter looks at two and three
        for (int i = 0; i < W; i++) begin
            if (r.s2[i] == r.s3[i]) begin
                next_r.q[i] = r.s3[i];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r <= '1;
        end else begin
            r <= next_r;
        end
    end

    assign q_o = r.q;
endmodule // dpsa_in_sync

// ### hdl/dpsa_port_ctrl.sv
// Controller for one port of a dual-port part's token space.
// Assumes the part's pins are wired directly; the other port is driven by another agent.
// Summary of operation
// R1: Master drives contention flag, slave receives it
// R2: Slave uses incoming flag only as write-inhibit
// R3: Exactly one master part per width-expanded array
// R4: Contention depends on address and select only
// R5: Hold address, select until flag settles; then write
// R6: Eight token latches, separate from memory array
// R7: Port idle means select and token-select high
// R8: Flags active low: zero requests, one releases
// R9: Token-select low routes access to token space
// R10: Each token has own address, both ports
// R11: Tokens gate nothing; meaning is software's
// R12: Write zero, read back before using resource
// R13: After failure poll, or withdraw and retry
// R14: Three low address lines, data bit zero
// R15: Read value latched while select and enable low
// R16: Pending zero transfers ownership on release
// R17: Simultaneous requests give token to one side
`timescale 1ns/1ps
module dpsa_port_ctrl
    import dpsa_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic cmd_valid_i,
    input wire logic [1:0] cmd_op_i,
    input wire logic [TOKEN_AW-1:0] cmd_token_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output logic rsp_granted_o,
    output logic rsp_flag_o,
    output logic rsp_inhibit_o,
    output logic ce_n_o,
    output logic flag_space_select_n_o,
    output logic rw_n_o,
    output logic oe_n_o,
    output logic [TOKEN_AW-1:0] addr_o,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_o,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic busy_n_i
);
    typedef struct packed {
        dpsa_state_t st;
        logic [1:0] op;
        logic [TOKEN_AW-1:0] tok;
        logic wr_val;
        logic last_rd;
        logic [CNT_W-1:0] cnt;
        logic [3:0] polls;
        logic granted;
        logic flag;
        logic inhib;
        logic rsp_valid;
        logic sem_n;
        logic rw_n;
        logic oe_n;
        logic dq_oe;
        logic seen_zero;
    } dpsa_regs_t;

    dpsa_regs_t r;
    dpsa_regs_t next_r;
    logic [1:0] pins_s;
    logic flag_s;
    logic busy_n_s;

    dpsa_in_sync #(
        .W(2)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .d_i({busy_n_i, data_i[0]}),
        .q_o(pins_s)
    );

    assign flag_s = pins_s[0];
    assign busy_n_s = pins_s[1];

    always_comb begin
        next_r = r;
        next_r.rsp_valid = 1'b0;
        if (r.cnt != CNT_ZERO) begin
            next_r.cnt = r.cnt - 8'h01;
        end
        unique case (r.st)
            DPSA_IDLE: begin
                if (cmd_valid_i) begin
                    next_r.op = cmd_op_i;
                    next_r.tok = (cmd_op_i == OP_INIT) ? TOKEN_FIRST : cmd_token_i;
                    next_r.polls = 4'h0;
                    next_r.granted = 1'b0;
                    next_r.seen_zero = 1'b0;
                    next_r.inhib = 1'b0;
                    next_r.sem_n = 1'b0; // [R9]
                    if (cmd_op_i == OP_POLL) begin
                        next_r.oe_n = 1'b0;
                        next_r.last_rd = 1'b1;
                        next_r.cnt = READ_LOAD;
                        next_r.st = DPSA_READ;
                    end else begin
                        // Zero requests the token, one releases it
                        next_r.wr_val = (cmd_op_i != OP_ACQUIRE); // [R8]
                        next_r.dq_oe = 1'b1;
                        next_r.last_rd = 1'b0;
                        next_r.cnt = SETTLE_LOAD;
                        next_r.st = DPSA_SETUP;
                    end
                end
            end
            DPSA_SETUP: begin
                // Address and select held while the contention flag settles
                if (r.cnt == CNT_ZERO) begin // [R5]
                    next_r.rw_n = 1'b0;
                    next_r.cnt = WPULSE_LOAD;
                    next_r.st = DPSA_WPULSE;
                    // Only one master drives this flag, so one sample suffices
                    next_r.inhib = r.inhib | ~busy_n_s; // [R3]
                end
            end
            DPSA_WPULSE: begin
                if (r.cnt == CNT_ZERO) begin
                    next_r.rw_n = 1'b1;
                    next_r.cnt = RECOV_LOAD;
                    next_r.st = DPSA_WRECOV;
                end
            end
            DPSA_WRECOV: begin
                // Data held past the rising strobe for hold time
                if (r.cnt == CNT_ZERO) begin
                    next_r.sem_n = 1'b1; // [R7]
                    next_r.dq_oe = 1'b0;
                    next_r.cnt = RECOV_LOAD;
                    next_r.st = DPSA_GAP;
                end
            end
            DPSA_READ: begin
                if (r.cnt == CNT_ZERO) begin
                    next_r.flag = flag_s; // [R14]
                    next_r.seen_zero = ~flag_s;
                    // Select and enable released so the latched value refreshes
                    next_r.oe_n = 1'b1; // [R15]
                    next_r.sem_n = 1'b1;
                    next_r.cnt = RECOV_LOAD;
                    next_r.st = DPSA_GAP;
                end
            end
            DPSA_GAP: begin
                if (r.cnt == CNT_ZERO) begin
                    next_r.st = DPSA_DONE;
                    if (r.op == OP_ACQUIRE && r.last_rd) begin
                        if (!r.flag) begin
                            next_r.granted = 1'b1; // [R12]
                        end else if (r.polls != POLL_LIMIT) begin
                            // Keep polling; a pending zero may turn into ownership
                            next_r.polls = r.polls + POLL_STEP; // [R13] [R16]
                            next_r.sem_n = 1'b0;
                            next_r.oe_n = 1'b0;
                            next_r.cnt = READ_LOAD;
                            next_r.st = DPSA_READ;
                        end else begin
                            // Withdraw, or the pending request would hang the other side
                            next_r.wr_val = 1'b1; // [R13]
                            next_r.sem_n = 1'b0;
                            next_r.dq_oe = 1'b1;
                            next_r.last_rd = 1'b0;
                            next_r.cnt = SETTLE_LOAD;
                            next_r.st = DPSA_SETUP;
                        end
                    end else if (r.op == OP_ACQUIRE && !r.wr_val) begin
                        next_r.sem_n = 1'b0; // [R12]
                        next_r.oe_n = 1'b0;
                        next_r.last_rd = 1'b1;
                        next_r.cnt = READ_LOAD;
                        next_r.st = DPSA_READ;
                    end else if (r.op == OP_INIT && r.tok != TOKEN_LAST) begin
                        next_r.tok = r.tok + TOKEN_STEP; // [R10]
                        next_r.sem_n = 1'b0;
                        next_r.dq_oe = 1'b1;
                        next_r.cnt = SETTLE_LOAD;
                        next_r.st = DPSA_SETUP;
                    end
                end
            end
            DPSA_DONE: begin
                next_r.rsp_valid = 1'b1;
                next_r.st = DPSA_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r <= '{st: DPSA_IDLE, sem_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1, flag: 1'b1, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign cmd_ready_o = (r.st == DPSA_IDLE);
    assign rsp_valid_o = r.rsp_valid;
    assign rsp_granted_o = r.granted;
    assign rsp_flag_o = r.flag;
    assign rsp_inhibit_o = r.inhib;
    // Token access keeps the array deselected
    assign ce_n_o = 1'b1; // [R9]
    assign flag_space_select_n_o = r.sem_n;
    assign rw_n_o = r.rw_n;
    assign oe_n_o = r.oe_n;
    assign addr_o = r.tok; // [R14]
    assign data_o = {DATA_W{r.wr_val}};
    assign data_oe_o = r.dq_oe;

    a_idle_standby: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R7]
        (r.st == DPSA_IDLE) |-> (flag_space_select_n_o && ce_n_o && oe_n_o && rw_n_o))
        else $error("port not in standby while idle");

    a_write_setup: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R5]
        $fell(rw_n_o) |-> $past(!flag_space_select_n_o && rw_n_o, SETTLE_CYC_I))
        else $error("write pulse started before settle time");

    a_addr_hold: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R5]
        !flag_space_select_n_o |-> $stable(addr_o) || $past(flag_space_select_n_o))
        else $error("address moved during token access");

    a_oe_rw_excl: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R9]
        !(!oe_n_o && (!rw_n_o || data_oe_o)))
        else $error("read enable overlaps write drive");

    a_readback_follows: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R12]
        ($rose(rw_n_o) && r.op == OP_ACQUIRE && !r.wr_val) |-> ##[1:20] !oe_n_o)
        else $error("request write not followed by readback");

    a_grant_read: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R12]
        (rsp_valid_o && rsp_granted_o) |-> (r.seen_zero && !rsp_flag_o && r.op == OP_ACQUIRE))
        else $error("grant reported without zero readback");

    a_poll_limit: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R13]
        r.polls <= POLL_LIMIT)
        else $error("poll count beyond limit");

    a_poll_bounded: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R13]
        (rsp_valid_o && r.op == OP_ACQUIRE && !rsp_granted_o)
        |-> (r.wr_val && r.polls == POLL_LIMIT))
        else $error("failed request not withdrawn after poll limit");

    a_release_one: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R8]
        ($fell(rw_n_o) && r.op != OP_ACQUIRE) |-> data_o[0])
        else $error("release or init wrote zero");

    a_read_release: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [R15]
        $fell(oe_n_o) |-> $past(flag_space_select_n_o) || $past(oe_n_o, 2))
        else $error("read enable not cycled between token reads");
endmodule // dpsa_port_ctrl

// ### test/dpsa_sem_model.sv
// Behavioural dual-port part: eight token latches and a busy flag.
// Assumes left pins come from the controller, right pins and busy from the bench.
`timescale 1ns/1ps
module dpsa_sem_model (
    input wire logic l_ce_n_i,
    input wire logic l_sem_n_i,
    input wire logic l_rw_n_i,
    input wire logic l_oe_n_i,
    input wire logic [2:0] l_addr_i,
    input wire logic [15:0] l_data_i,
    output logic [15:0] l_data_o,
    input wire logic hold_off_i,
    output logic busy_n_o,
    input wire logic r_sem_n_i,
    input wire logic r_rw_n_i,
    input wire logic [2:0] r_addr_i,
    input wire logic r_d0_i,
    output logic [7:0] r_flag_o
);
    // Owner per token: 0 free, 1 left, 2 right; power-up left-owned so init matters
    logic [7:0][1:0] own = {8{2'h1}};
    logic [7:0] req_l = 8'h00;
    logic [7:0] req_r = 8'hff;
    logic rlat = 1'b1;
    wire rd_n = l_sem_n_i | l_oe_n_i;
    // Single master flag; read or write never enters it
    assign busy_n_o = ~hold_off_i;
    task upd(input int t);
        if (own[t] == 2'h1 && req_l[t]) own[t] = req_r[t] ? 2'h0 : 2'h2;
        if (own[t] == 2'h2 && req_r[t]) own[t] = req_l[t] ? 2'h0 : 2'h1;
        if (own[t] == 2'h0) own[t] = !req_l[t] ? 2'h1 : (!req_r[t] ? 2'h2 : 2'h0);
    endtask
    // Inhibited writes vanish, as on a slave part
    always @(posedge l_rw_n_i) begin
        if (!l_sem_n_i && l_ce_n_i && busy_n_o) begin
            req_l[l_addr_i] = l_data_i[0];
            upd(l_addr_i);
        end
    end
    always @(posedge r_rw_n_i) begin
        if (!r_sem_n_i) begin
            req_r[r_addr_i] = r_d0_i;
            upd(r_addr_i);
        end
    end
    // Address settles past the select edge before the value is latched
    always @(negedge rd_n) begin
        #1;
        rlat = own[l_addr_i] != 2'h1;
    end
    // Off the bus the lines show the inverse, never a stale copy
    assign l_data_o = rd_n ? {16{~rlat}} : {16{rlat}};
    always_comb foreach (r_flag_o[i]) r_flag_o[i] = own[i] != 2'h2;
endmodule // dpsa_sem_model

// ### test/testbench.sv
// Self-checking bench for the token-space controller.
// Assumes the part model on the far side; right port and busy driven here.
`timescale 1ns/1ps
module testbench
    import dpsa_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    logic [1:0] cmd_op_i = 2'h0;
    logic [2:0] cmd_token_i = 3'h0;
    logic cmd_ready_o, rsp_valid_o, rsp_granted_o, rsp_flag_o, rsp_inhibit_o;
    logic ce_n_o, flag_space_select_n_o, rw_n_o, oe_n_o, data_oe_o, busy_n_i;
    logic [2:0] addr_o;
    logic [15:0] data_o, data_i;
    logic hold_off = 1'b0;
    logic r_sem_n = 1'b1;
    logic r_rw_n = 1'b1;
    logic [2:0] r_addr = 3'h0;
    logic r_d0 = 1'b1;
    logic [7:0] r_flag;
    int errors = 0;
    int num_checks = 0;
    int lat;
    typedef struct {
        logic [1:0] pre;
        logic [1:0] op;
        logic [2:0] tk;
        int lat;
        logic g;
        logic f;
        logic rf;
    } dpsa_row_t;
    // pre: 1 right requests the token first, 2 right releases it first
    dpsa_row_t rows [17] = '{
        '{0, OP_INIT, 0, 73, 0, 1, 1}, '{0, OP_ACQUIRE, 0, 19, 1, 0, 1},
        '{0, OP_POLL, 0, 10, 0, 0, 1}, '{0, OP_RELEASE, 0, 10, 0, 0, 1},
        '{0, OP_POLL, 0, 10, 0, 1, 1}, '{0, OP_ACQUIRE, 5, 19, 1, 0, 1},
        '{1, OP_POLL, 5, 10, 0, 0, 1}, '{0, OP_RELEASE, 5, 10, 0, 0, 0},
        '{0, OP_POLL, 5, 10, 0, 1, 0}, '{2, OP_ACQUIRE, 5, 19, 1, 0, 1},
        '{0, OP_RELEASE, 5, 10, 0, 0, 1}, '{1, OP_ACQUIRE, 2, 100, 0, 1, 0},
        '{2, OP_ACQUIRE, 2, 19, 1, 0, 1}, '{0, OP_POLL, 6, 10, 0, 1, 1},
        '{0, OP_RELEASE, 2, 10, 0, 0, 1}, '{0, OP_ACQUIRE, 7, 19, 1, 0, 1},
        '{0, OP_RELEASE, 7, 10, 0, 0, 1}};
    always #(CLK_PERIOD_NS / 2) sys_clk_i = ~sys_clk_i;
    dpsa_port_ctrl dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i),
        .cmd_op_i(cmd_op_i), .cmd_token_i(cmd_token_i), .cmd_ready_o(cmd_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_granted_o(rsp_granted_o), .rsp_flag_o(rsp_flag_o),
        .rsp_inhibit_o(rsp_inhibit_o), .ce_n_o(ce_n_o),
        .flag_space_select_n_o(flag_space_select_n_o), .rw_n_o(rw_n_o), .oe_n_o(oe_n_o),
        .addr_o(addr_o), .data_o(data_o), .data_oe_o(data_oe_o), .data_i(data_i),
        .busy_n_i(busy_n_i));
    dpsa_sem_model part (.l_ce_n_i(ce_n_o), .l_sem_n_i(flag_space_select_n_o),
        .l_rw_n_i(rw_n_o), .l_oe_n_i(oe_n_o), .l_addr_i(addr_o), .l_data_i(data_o),
        .l_data_o(data_i), .hold_off_i(hold_off), .busy_n_o(busy_n_i),
        .r_sem_n_i(r_sem_n), .r_rw_n_i(r_rw_n), .r_addr_i(r_addr), .r_d0_i(r_d0),
        .r_flag_o(r_flag));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Called at a falling edge; returns cycles from taking edge to the done pulse
    task automatic run(input logic [1:0] op, input logic [2:0] tk, output int n);
        n = 0;
        while (cmd_ready_o !== 1'b1 && n < 200) begin
            @(negedge sys_clk_i);
            n++;
        end
        cmd_op_i = op;
        cmd_token_i = tk;
        cmd_valid_i = 1'b1;
        @(negedge sys_clk_i);
        cmd_valid_i = 1'b0;
        n = 0;
        while (rsp_valid_o !== 1'b1 && n < 300) begin
            @(negedge sys_clk_i);
            n++;
        end
    endtask
    task automatic rwr(input logic [2:0] tk, input logic b);
        r_addr = tk;
        r_d0 = b;
        r_sem_n = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        r_rw_n = 1'b0;
        @(negedge sys_clk_i);
        r_rw_n = 1'b1;
        @(negedge sys_clk_i);
        r_sem_n = 1'b1;
    endtask
    // Write strobe may fall only after address and select have settled
    int sc = 0;
    logic [2:0] pa = 3'h0;
    logic prw = 1'b1;
    always @(negedge sys_clk_i) begin
        if (rw_n_o === 1'b0 && prw === 1'b1) begin
            chk("setup", sc, 3);
            chk("array off", ce_n_o, 1);
        end
        if (flag_space_select_n_o === 1'b0) sc = (addr_o === pa) ? sc + 1 : 1;
        else sc = 0;
        pa = addr_o;
        prw = rw_n_o;
    end
    // About twenty times the expected run length
    initial begin
        #100000;
        errors++;
        wrap_up;
    end
    initial begin
        repeat (20) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        chk("ready", cmd_ready_o, 1);
        foreach (rows[i]) begin
            if (rows[i].pre != 2'h0) rwr(rows[i].tk, rows[i].pre == 2'h2);
            run(rows[i].op, rows[i].tk, lat);
            chk("latency", lat, rows[i].lat);
            chk("granted", rsp_granted_o, rows[i].g);
            if (rows[i].op < 2) chk("flag", rsp_flag_o, rows[i].f);
            chk("right flag", r_flag[rows[i].tk], rows[i].rf);
            @(negedge sys_clk_i);
            chk("pulse", rsp_valid_o, 0);
            chk("standby", {ce_n_o, flag_space_select_n_o}, 2'h3);
        end
        hold_off = 1'b1;
        // Flag must pass the synchroniser before the write pulse starts
        repeat (4) @(negedge sys_clk_i);
        run(OP_ACQUIRE, 3'h3, lat);
        chk("inhibit", rsp_inhibit_o, 1);
        chk("inhibited grant", rsp_granted_o, 0);
        hold_off = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        run(OP_ACQUIRE, 3'h3, lat);
        chk("inhibit clear", rsp_inhibit_o, 0);
        chk("grant", rsp_granted_o, 1);
        cmd_op_i = OP_POLL;
        cmd_valid_i = 1'b1;
        @(negedge sys_clk_i);
        cmd_valid_i = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        nrst_i = 1'b0;
        @(negedge sys_clk_i);
        chk("reset pins", {cmd_ready_o, rsp_valid_o, rsp_flag_o, flag_space_select_n_o,
            oe_n_o, data_oe_o}, 6'h2e);
        nrst_i = 1'b1;
        run(OP_POLL, 3'h3, lat);
        chk("after reset", rsp_flag_o, 0);
        run(OP_RELEASE, 3'h3, lat);
        wrap_up;
    end
endmodule // testbench
